// file: verilog/stop_pkg.sv
// shared constants, register map and carriers for the stop-mode controller
package stop_pkg;
    // register byte addresses
    localparam logic [3:0] CTRL_ADDR    = 4'h0;
    localparam logic [3:0] STATUS_ADDR  = 4'h4;
    // control register fields
    localparam int CTRL_DBG_EN   = 0;
    localparam int CTRL_STOP_EN  = 1;
    localparam int CTRL_PPD_SEL  = 2;
    localparam int CTRL_LVD_EN   = 3;
    localparam int CTRL_LVD_SE   = 4;
    localparam int CTRL_CLK_RUN  = 5;
    localparam int CTRL_ADC_ASY  = 6;
    localparam int CTRL_RTI_EN   = 7;
    localparam int CTRL_PPD_ACK  = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // status register fields
    localparam int STAT_PPD_FLAG = 0;
    localparam int STAT_MODE_LSB = 1;
    localparam int STAT_DBG_ACT  = 3;
    localparam int STAT_PINLATCH = 4;
    // debug command codes
    localparam logic [7:0] CMD_HALT     = 8'h90;
    localparam logic [7:0] CMD_RD_STAT  = 8'hE0;
    localparam logic [7:0] CMD_WR_STAT  = 8'hC0;
    localparam logic [7:0] CMD_RD_CTRL  = 8'hE4;
    // debug answer status codes
    localparam logic [1:0] RESP_OK      = 2'h0;
    localparam logic [1:0] RESP_STOPPED = 2'h1;
    localparam logic [1:0] RESP_REJECT  = 2'h2;
    // cycles between clock restore and cpu release
    localparam logic [1:0] WAKE_CYCLES  = 2'h2;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_RETAIN,
        MODE_DEEP,
        MODE_DEBUG
    } pmode_e;

    typedef struct packed {
        logic debug_entry_enable;
        logic stop_enable_option;
        logic partial_powerdown_select;
        logic low_voltage_detect_enable;
        logic low_voltage_detect_stop_enable;
        logic clk_run_in_stop;
        logic adc_async_clk;
        logic rti_enable;
    } ctrl_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } dbg_cmd_s;

    typedef struct packed {
        logic       valid;
        logic [1:0] status;
        logic       memory_access;
    } dbg_resp_s;

    typedef struct packed {
        logic debug_clk_en;
        logic periph_clk_en;
        logic regulator_full;
        logic clk_source_on;
        logic adc_on;
        logic rti_on;
        logic cpu_standby;
        logic pin_latch;
    } pwr_ctl_s;
endpackage : stop_pkg

// file: verilog/stop_regs.sv
// wishbone register slave for stop-mode control and status
`timescale 1ns/10ps
module stop_regs
(
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [3:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    // block side
    input  wire logic [7:0]      status_i,
    output stop_pkg::ctrl_s      ctrl_o,
    output logic                 ppd_ack_o
);
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic        ack_pulse_r;
    logic        ack_pulse_nxt;
    logic        req;

    assign req = wb_cyc_i && wb_stb_i && !ack_r;

    always_comb
    begin
        ctrl_nxt      = ctrl_r;
        ack_nxt       = req;
        dat_nxt       = dat_r;
        ack_pulse_nxt = 1'b0;
        if (req && wb_we_i && wb_adr_i == stop_pkg::CTRL_ADDR)
        begin
            if (wb_sel_i[0])
                ctrl_nxt = wb_dat_i[7:0];
            // acknowledge is write-one, never stored
            if (wb_sel_i[1])
                ack_pulse_nxt = wb_dat_i[stop_pkg::CTRL_PPD_ACK];
        end
        if (req && !wb_we_i)
        begin
            case (wb_adr_i)
                stop_pkg::CTRL_ADDR:   dat_nxt = {24'h000000, ctrl_r};
                stop_pkg::STATUS_ADDR: dat_nxt = {24'h000000, status_i};
                default:               dat_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_r      <= stop_pkg::CTRL_RESET;
            ack_r       <= 1'b0;
            dat_r       <= 32'h00000000;
            ack_pulse_r <= 1'b0;
        end
        else
        begin
            ctrl_r      <= ctrl_nxt;
            ack_r       <= ack_nxt;
            dat_r       <= dat_nxt;
            ack_pulse_r <= ack_pulse_nxt;
        end
    end

    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = dat_r;
    // fields are picked by their register bit, not by the carrier's layout
    always_comb
    begin
        ctrl_o.debug_entry_enable = ctrl_r[stop_pkg::CTRL_DBG_EN];
        ctrl_o.stop_enable_option = ctrl_r[stop_pkg::CTRL_STOP_EN];
        ctrl_o.partial_powerdown_select = ctrl_r[stop_pkg::CTRL_PPD_SEL];
        ctrl_o.low_voltage_detect_enable = ctrl_r[stop_pkg::CTRL_LVD_EN];
        ctrl_o.low_voltage_detect_stop_enable = ctrl_r[stop_pkg::CTRL_LVD_SE];
        ctrl_o.clk_run_in_stop = ctrl_r[stop_pkg::CTRL_CLK_RUN];
        ctrl_o.adc_async_clk = ctrl_r[stop_pkg::CTRL_ADC_ASY];
        ctrl_o.rti_enable = ctrl_r[stop_pkg::CTRL_RTI_EN];
    end
    assign ppd_ack_o = ack_pulse_r;
endmodule : stop_regs

// file: verilog/dbg_gate.sv
// filters debug link commands by power mode
`timescale 1ns/10ps
module dbg_gate
(
    // mode
    input  wire logic              stopped_i,
    // command in and out
    input  stop_pkg::dbg_cmd_s     cmd_i,
    output stop_pkg::dbg_resp_s    resp_o,
    output logic                   halt_o
);
    function automatic logic is_status_cmd(input logic [7:0] code);
        is_status_cmd = (code == stop_pkg::CMD_RD_STAT) ||
                        (code == stop_pkg::CMD_WR_STAT);
    endfunction : is_status_cmd

    always_comb
    begin
        resp_o.valid         = cmd_i.valid;
        resp_o.status        = stop_pkg::RESP_OK;
        resp_o.memory_access = cmd_i.valid;
        halt_o               = cmd_i.valid &&
                               cmd_i.code == stop_pkg::CMD_HALT;
        if (stopped_i && cmd_i.valid)
        begin
            resp_o.memory_access = 1'b0;
            if (is_status_cmd(cmd_i.code))
                resp_o.status = stop_pkg::RESP_STOPPED;
            else if (cmd_i.code != stop_pkg::CMD_HALT)
                resp_o.status = stop_pkg::RESP_REJECT;
        end
    end
endmodule : dbg_gate

// file: verilog/stop_power_ctl.sv
// stop-mode power controller top level
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
module stop_power_ctl
(
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [3:0]      wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [31:0]     wb_dat_i,
    output logic      [31:0]     wb_dat_o,
    output logic                 wb_ack_o,
    // cpu core
    input  wire logic            stop_req_i,
    input  wire logic            bgnd_req_i,
    input  wire logic            wake_irq_i,
    input  wire logic            wake_deep_i,
    input  wire logic            debug_go_i,
    output logic                 cpu_run_o,
    output logic                 illegal_rst_o,
    output logic                 por_restart_o,
    // debug link
    input  stop_pkg::dbg_cmd_s   dbg_cmd_i,
    output stop_pkg::dbg_resp_s  dbg_resp_o,
    output logic                 dbg_active_o,
    // power controls
    output stop_pkg::pwr_ctl_s   pwr_o
);
    stop_pkg::ctrl_s   ctrl;
    logic              ppd_ack;
    logic              halt_cmd;
    logic              stopped;
    logic [7:0]        status;

    stop_pkg::pmode_e  mode_r, mode_nxt;
    logic              dbg_stop_r, dbg_stop_nxt;
    logic              lvd_stop_r, lvd_stop_nxt;
    logic              ppd_flag_r, ppd_flag_nxt;
    logic              pin_latch_r, pin_latch_nxt;
    logic [1:0]        wake_cnt_r, wake_cnt_nxt;
    logic              illegal_r, illegal_nxt;
    logic              por_r, por_nxt;
    stop_pkg::pwr_ctl_s pwr_r, pwr_nxt;
    logic              lvd_in_stop;

    stop_regs u_regs
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_adr_i  (wb_adr_i),
        .wb_sel_i  (wb_sel_i),
        .wb_dat_i  (wb_dat_i),
        .wb_dat_o  (wb_dat_o),
        .wb_ack_o  (wb_ack_o),
        .status_i  (status),
        .ctrl_o    (ctrl),
        .ppd_ack_o (ppd_ack)
    );

    assign stopped = (mode_r == stop_pkg::MODE_RETAIN);

    dbg_gate u_gate
    (
        .stopped_i (stopped),
        .cmd_i     (dbg_cmd_i),
        .resp_o    (dbg_resp_o),
        .halt_o    (halt_cmd)
    );

    assign lvd_in_stop = ctrl.low_voltage_detect_enable &&
                         ctrl.low_voltage_detect_stop_enable;

    always_comb
    begin
        status = 8'h00;
        status[stop_pkg::STAT_PPD_FLAG] = ppd_flag_r;
        status[stop_pkg::STAT_MODE_LSB +: 2] = mode_r;
        status[stop_pkg::STAT_DBG_ACT] = (mode_r == stop_pkg::MODE_DEBUG);
        status[stop_pkg::STAT_PINLATCH] = pin_latch_r;
    end

    // mode sequencing
    always_comb
    begin
        mode_nxt      = mode_r;
        dbg_stop_nxt  = dbg_stop_r;
        lvd_stop_nxt  = lvd_stop_r;
        ppd_flag_nxt  = ppd_flag_r;
        pin_latch_nxt = pin_latch_r;
        wake_cnt_nxt  = wake_cnt_r;
        illegal_nxt   = 1'b0;
        por_nxt       = 1'b0;
        case (mode_r)
            stop_pkg::MODE_RUN:
            begin
                if (wake_cnt_r != 2'h0)
                    wake_cnt_nxt = wake_cnt_r - 2'h1;
                else if ((bgnd_req_i || halt_cmd) && ctrl.debug_entry_enable)
                    mode_nxt = stop_pkg::MODE_DEBUG;
                else if (stop_req_i)
                begin
                    if (!ctrl.stop_enable_option)
                        illegal_nxt = 1'b1;
                    // choice frozen at the stop instruction
                    else if (ctrl.partial_powerdown_select &&
                             !ctrl.debug_entry_enable && !lvd_in_stop)
                    begin
                        mode_nxt      = stop_pkg::MODE_DEEP;
                        pin_latch_nxt = 1'b1;
                    end
                    else
                    begin
                        mode_nxt     = stop_pkg::MODE_RETAIN;
                        dbg_stop_nxt = ctrl.debug_entry_enable;
                        lvd_stop_nxt = lvd_in_stop;
                    end
                end
            end
            stop_pkg::MODE_RETAIN:
            begin
                if (halt_cmd && dbg_stop_r)
                begin
                    mode_nxt     = stop_pkg::MODE_DEBUG;
                    wake_cnt_nxt = stop_pkg::WAKE_CYCLES;
                end
                else if (wake_irq_i)
                begin
                    mode_nxt     = stop_pkg::MODE_RUN;
                    wake_cnt_nxt = stop_pkg::WAKE_CYCLES;
                end
            end
            stop_pkg::MODE_DEEP:
            begin
                if (wake_deep_i)
                begin
                    mode_nxt     = stop_pkg::MODE_RUN;
                    ppd_flag_nxt = 1'b1;
                    por_nxt      = 1'b1;
                end
            end
            stop_pkg::MODE_DEBUG:
            begin
                if (wake_cnt_r != 2'h0)
                    wake_cnt_nxt = wake_cnt_r - 2'h1;
                else if (debug_go_i)
                    mode_nxt = stop_pkg::MODE_RUN;
            end
            default:
                mode_nxt = stop_pkg::MODE_RUN;
        endcase
        // the wake event that sets the flag wins over an acknowledge
        if (ppd_ack && !(mode_r == stop_pkg::MODE_DEEP && wake_deep_i))
        begin
            ppd_flag_nxt  = 1'b0;
            pin_latch_nxt = 1'b0;
        end
    end

    // power control outputs
    always_comb
    begin
        pwr_nxt = '0;
        pwr_nxt.pin_latch = pin_latch_nxt;
        case (mode_nxt)
            stop_pkg::MODE_RETAIN:
            begin
                pwr_nxt.periph_clk_en  = 1'b0;
                pwr_nxt.cpu_standby    = 1'b1;
                pwr_nxt.debug_clk_en   = dbg_stop_nxt;
                pwr_nxt.regulator_full = dbg_stop_nxt || lvd_stop_nxt;
                pwr_nxt.clk_source_on  = dbg_stop_nxt ||
                                         ctrl.clk_run_in_stop;
                pwr_nxt.adc_on         = ctrl.adc_async_clk &&
                                         lvd_stop_nxt;
                pwr_nxt.rti_on         = ctrl.rti_enable;
                pwr_nxt.pin_latch      = 1'b1;
            end
            stop_pkg::MODE_DEEP:
            begin
                pwr_nxt.periph_clk_en = 1'b0;
                pwr_nxt.cpu_standby   = 1'b1;
                pwr_nxt.rti_on        = ctrl.rti_enable;
                pwr_nxt.pin_latch     = 1'b1;
            end
            default:
            begin
                pwr_nxt.periph_clk_en  = 1'b1;
                pwr_nxt.debug_clk_en   = 1'b1;
                pwr_nxt.regulator_full = 1'b1;
                pwr_nxt.clk_source_on  = 1'b1;
                pwr_nxt.adc_on         = 1'b1;
                pwr_nxt.rti_on         = ctrl.rti_enable;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_r      <= stop_pkg::MODE_RUN;
            dbg_stop_r  <= 1'b0;
            lvd_stop_r  <= 1'b0;
            ppd_flag_r  <= 1'b0;
            pin_latch_r <= 1'b0;
            wake_cnt_r  <= 2'h0;
            illegal_r   <= 1'b0;
            por_r       <= 1'b0;
            pwr_r       <= '0;
        end
        else
        begin
            mode_r      <= mode_nxt;
            dbg_stop_r  <= dbg_stop_nxt;
            lvd_stop_r  <= lvd_stop_nxt;
            ppd_flag_r  <= ppd_flag_nxt;
            pin_latch_r <= pin_latch_nxt;
            wake_cnt_r  <= wake_cnt_nxt;
            illegal_r   <= illegal_nxt;
            por_r       <= por_nxt;
            pwr_r       <= pwr_nxt;
        end
    end

    assign pwr_o         = pwr_r;
    assign illegal_rst_o = illegal_r;
    assign por_restart_o = por_r;
    assign dbg_active_o  = (mode_r == stop_pkg::MODE_DEBUG);
    assign cpu_run_o     = (mode_r == stop_pkg::MODE_RUN) &&
                           (wake_cnt_r == 2'h0);

    sequence s_retain_entry;
        mode_r == stop_pkg::MODE_RUN && wake_cnt_r == 2'h0 && stop_req_i
        && !bgnd_req_i && !halt_cmd && ctrl.stop_enable_option;
    endsequence

    a_debug_stop_demote: assert property (@(posedge clk_i) disable iff (rst_i)
        s_retain_entry and ctrl.debug_entry_enable
        |=> mode_r == stop_pkg::MODE_RETAIN)
        else $error("deep stop not demoted with debug enabled");
    a_lvd_stop_demote: assert property (@(posedge clk_i) disable iff (rst_i)
        s_retain_entry and lvd_in_stop
        |=> mode_r == stop_pkg::MODE_RETAIN && pwr_o.regulator_full)
        else $error("deep stop not demoted with detector enabled");
    a_deep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        s_retain_entry and (ctrl.partial_powerdown_select
        && !ctrl.debug_entry_enable && !lvd_in_stop)
        |=> mode_r == stop_pkg::MODE_DEEP && pwr_o.pin_latch)
        else $error("deep stop not entered when selected");
    a_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ppd_flag_r && !ppd_ack |=> ppd_flag_r)
        else $error("deep wake flag lost without acknowledge");
    a_debug_clk_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        stopped && dbg_stop_r |-> pwr_o.debug_clk_en
        && pwr_o.regulator_full && pwr_o.clk_source_on)
        else $error("debug clocks or regulator dropped in stop");
    a_periph_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_r == stop_pkg::MODE_RETAIN || mode_r == stop_pkg::MODE_DEEP
        |-> !pwr_o.periph_clk_en)
        else $error("peripheral clock running in stop");
    a_illegal_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_r == stop_pkg::MODE_RUN && wake_cnt_r == 2'h0 && stop_req_i
        && !ctrl.stop_enable_option && !bgnd_req_i && !halt_cmd
        |=> illegal_rst_o && mode_r == stop_pkg::MODE_RUN)
        else $error("illegal stop not reset");
    a_halt_wakes: assert property (@(posedge clk_i) disable iff (rst_i)
        stopped && halt_cmd && dbg_stop_r
        |=> dbg_active_o ##1 !cpu_run_o)
        else $error("halt did not wake into debug");
    a_stop_filter: assert property (@(posedge clk_i) disable iff (rst_i)
        stopped && dbg_cmd_i.valid |-> !dbg_resp_o.memory_access)
        else $error("memory access performed while stopped");
    a_ppd_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_r == stop_pkg::MODE_DEEP && wake_deep_i
        |=> ppd_flag_r && por_restart_o && pwr_o.pin_latch)
        else $error("deep wake flag missing");
    a_adc_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        stopped && !lvd_stop_r |-> !pwr_o.adc_on)
        else $error("converter on in stop without detector");
    a_wake_order: assert property (@(posedge clk_i) disable iff (rst_i)
        stopped && wake_irq_i && !(halt_cmd && dbg_stop_r)
        |=> pwr_o.periph_clk_en && !cpu_run_o ##2 cpu_run_o)
        else $error("cpu released before clocks");
endmodule : stop_power_ctl

// file: verif/host_model.sv
// cpu core and debug host stimulus model for the stop controller
`timescale 1ns/10ps
module host_model
(
    // clock
    input  wire logic           clk_i,
    // cpu events: stop, bgnd, wake_irq, wake_deep, debug_go
    output logic [4:0]          ev_o,
    // debug link
    output stop_pkg::dbg_cmd_s  cmd_o
);
    initial
    begin
        ev_o = 5'h00;
        cmd_o = '0;
    end
    // core events last one cycle, the way an instruction issues them
    task automatic pulse(input int i);
        @(posedge clk_i);
        ev_o[i] <= 1'b1;
        @(posedge clk_i);
        ev_o[i] <= 1'b0;
        #1;
    endtask : pulse
    // answer is combinational, so it is read in the valid cycle
    task automatic send(input logic [7:0] c);
        @(posedge clk_i);
        cmd_o <= '{valid: 1'b1, code: c};
        #1;
    endtask : send
    // a released link shows no stale code
    task automatic idle();
        @(posedge clk_i);
        cmd_o <= '{valid: 1'b0, code: ~cmd_o.code};
    endtask : idle
endmodule : host_model

// file: verif/tb_stop_power_ctl.sv
// self-checking bench for the stop-mode power controller
`timescale 1ns/10ps
module tb_stop_power_ctl;
    logic                clk_i;
    logic                rst_i;
    logic                wb_cyc;
    logic                wb_stb;
    logic                wb_we;
    logic [3:0]          wb_adr;
    logic [3:0]          wb_sel;
    logic [31:0]         wb_dat;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o;
    logic                cpu_run_o;
    logic                illegal_rst_o;
    logic                por_restart_o;
    logic                dbg_active_o;
    logic [4:0]          ev;
    stop_pkg::dbg_cmd_s  cmd;
    stop_pkg::dbg_resp_s resp;
    stop_pkg::pwr_ctl_s  pwr;
    logic [31:0]         d;
    logic [31:0]         lf;
    logic [7:0]          c;
    logic                dbg;
    logic                low_voltage_detector;
    int                  m;
    int                  errors;
    int                  checks;
    logic [7:0]          tbl [$] = '{8'h02, 8'h06, 8'h07, 8'h1E,
                                     8'h7A, 8'h42, 8'h00, 8'h86};

    stop_power_ctl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .stop_req_i(ev[0]), .bgnd_req_i(ev[1]),
        .wake_irq_i(ev[2]), .wake_deep_i(ev[3]), .debug_go_i(ev[4]),
        .cpu_run_o(cpu_run_o), .illegal_rst_o(illegal_rst_o),
        .por_restart_o(por_restart_o), .dbg_cmd_i(cmd),
        .dbg_resp_o(resp), .dbg_active_o(dbg_active_o), .pwr_o(pwr));
    host_model host_u (.clk_i(clk_i), .ev_o(ev), .cmd_o(cmd));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    // reference: 0 refused, 1 state-retaining, 2 deep
    function automatic int exp_mode(input logic [7:0] x);
        if (!x[stop_pkg::CTRL_STOP_EN])
            return 0;
        if (x[stop_pkg::CTRL_DBG_EN] || x[3] && x[4])
            return 1;
        return x[stop_pkg::CTRL_PPD_SEL] ? 2 : 1;
    endfunction : exp_mode

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen,
                     exp);
        end
    endtask : chk

    // one classic cycle; the wait is bounded, never assumed
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [3:0] s, input logic [31:0] di,
                      output logic [31:0] dq);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat <= di;
        @(posedge clk_i);
        n = 1;
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        dq = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        // idle qualifiers wander so a slave that ignores cyc and stb shows up
        lf = lfsr(lf);
        wb_we <= lf[0];
        wb_adr <= lf[4:1];
        wb_sel <= lf[8:5];
        wb_dat <= lf;
        if (n >= 20)
        begin
            errors++;
            finish_test();
        end
    endtask : wb

    initial
    begin
        {rst_i, wb_cyc, wb_stb, wb_we} = 4'h8;
        {wb_adr, wb_sel, wb_dat} = '0;
        lf = 32'hC801;
        errors = 0;
        checks = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(cpu_run_o, 1);
        wb(1'b1, stop_pkg::CTRL_ADDR, 4'hF, 32'h1FF, d);
        wb(1'b1, 4'h8, 4'hF, 32'hFF, d);
        wb(1'b0, 4'h8, 4'hF, 32'h0, d);
        chk(d, 32'h0);
        wb(1'b0, stop_pkg::CTRL_ADDR, 4'hF, 32'h0, d);
        chk(d[8:0], 9'h0FF);
        foreach (tbl[i])
        begin
            c = tbl[i];
            m = exp_mode(c);
            dbg = c[stop_pkg::CTRL_DBG_EN];
            low_voltage_detector = c[stop_pkg::CTRL_LVD_EN] & c[stop_pkg::CTRL_LVD_SE];
            wb(1'b1, stop_pkg::CTRL_ADDR, 4'h1, {24'h0, c}, d);
            host_u.pulse(0);
            if (m == 0)
                chk(illegal_rst_o, 1);
            else
            begin
                chk(pwr.periph_clk_en, 0);
                chk(cpu_run_o, 0);
                chk(pwr.debug_clk_en, dbg);
                chk(pwr.regulator_full, dbg | low_voltage_detector);
                chk(pwr.cpu_standby, 1);
                chk(pwr.rti_on, c[stop_pkg::CTRL_RTI_EN]);
            end
            if (m == 1)
            begin
                chk(pwr.clk_source_on, dbg | c[5]);
                chk(pwr.adc_on, c[6] & low_voltage_detector);
                wb(1'b0, stop_pkg::STATUS_ADDR, 4'hF, 32'h0, d);
                chk(d[2:1], 2'h1);
                host_u.pulse(2);
                chk(pwr.periph_clk_en, 1);
                chk(cpu_run_o, 0);
                repeat (stop_pkg::WAKE_CYCLES) @(posedge clk_i);
                #1;
                chk(cpu_run_o, 1);
            end
            if (m == 2)
            begin
                chk(pwr.pin_latch, 1);
                host_u.pulse(3);
                chk(por_restart_o, 1);
                wb(1'b0, stop_pkg::STATUS_ADDR, 4'hF, 32'h0, d);
                chk(d[4:0], 5'h11);
                wb(1'b1, stop_pkg::CTRL_ADDR, 4'h2, 32'h100, d);
                wb(1'b0, stop_pkg::STATUS_ADDR, 4'hF, 32'h0, d);
                chk(d[4:0], 5'h00);
            end
        end
        wb(1'b1, stop_pkg::CTRL_ADDR, 4'h1, 32'h07, d);
        host_u.pulse(0);
        for (int k = 0; k < 6; k++)
        begin
            lf = lfsr(lf);
            // odd codes never hit halt or the status commands
            c = (k < 4) ? lf[7:0] | 8'h01 : k[0] ? 8'hC0 : 8'hE0;
            host_u.send(c);
            if (k < 4)
                chk({resp.valid, resp.status},
                    {1'b1, stop_pkg::RESP_REJECT});
            else
                chk({resp.status, resp.memory_access}, 3'h2);
        end
        host_u.send(stop_pkg::CMD_HALT);
        host_u.idle();
        #1;
        chk(dbg_active_o, 1);
        chk(pwr.periph_clk_en, 1);
        host_u.send(stop_pkg::CMD_RD_CTRL);
        chk(resp.status, stop_pkg::RESP_OK);
        host_u.idle();
        host_u.pulse(4);
        wb(1'b1, stop_pkg::CTRL_ADDR, 4'h1, 32'h00, d);
        host_u.pulse(1);
        chk(dbg_active_o, 0);
        wb(1'b1, stop_pkg::CTRL_ADDR, 4'h1, 32'h01, d);
        host_u.pulse(1);
        chk(dbg_active_o, 1);
        host_u.pulse(4);
        wb(1'b1, stop_pkg::CTRL_ADDR, 4'h1, 32'h02, d);
        host_u.pulse(0);
        host_u.send(stop_pkg::CMD_HALT);
        host_u.idle();
        #1;
        chk(dbg_active_o, 0);
        finish_test();
    end
endmodule : tb_stop_power_ctl
